// >>> verilog/pnfs_sequencer.sv
// Operation
// - Host writes with strobe low, select low
// - Read only with select and gate low
// - Host erases sector before programming word; the program op does not erase, the caller does
// - Program: two unlock cycles and A0H, then address/data
// - Sector erase: six cycles, 30H last
// - Block erase: six cycles, 50H last
// - Chip erase: six cycles, 10H at 5555H
`timescale 1ns/1ps

module pnfs_sequencer
#(
    // Erase completion budget in clock cycles
    parameter int ERASE_TIMEOUT_CYC = pnfs_pkg::ERASE_TIMEOUT_DEF
)
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // User command port
    input  wire logic                          cmd_valid,
    input  wire logic [2:0]                    cmd_op,
    input  wire logic [pnfs_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic [pnfs_pkg::DATA_W-1:0]   cmd_wdata,
    output logic                               cmd_ready,
    // User response port
    output logic                               rsp_valid,
    output logic [pnfs_pkg::DATA_W-1:0]        rsp_rdata,
    output logic                               rsp_timeout,
    // Flash pins
    output logic [pnfs_pkg::ADDR_W-1:0]        address_lines,
    output logic                               chip_sel_n,
    output logic                               out_gate_n,
    output logic                               wr_strobe_n,
    output logic [pnfs_pkg::DATA_W-1:0]        data_lines_wr,
    output logic                               data_lines_wr_en,
    input  wire logic [pnfs_pkg::DATA_W-1:0]   data_lines_rd
);

    // Sequencer states, Gray coded from IDLE to FINAL along the write and poll path
    typedef enum logic [2:0]
    {
        PNFS_ST_IDLE  = 3'b000,
        PNFS_ST_CMD   = 3'b001,
        PNFS_ST_POLL1 = 3'b011,
        PNFS_ST_POLL2 = 3'b010,
        PNFS_ST_FINAL = 3'b110,
        PNFS_ST_READ  = 3'b100
    } pnfs_st_e;

    // Address and data of one command step
    typedef struct packed
    {
        logic [pnfs_pkg::ADDR_W-1:0] addr;
        logic [pnfs_pkg::DATA_W-1:0] data;
    } pnfs_step_s;

    // Bus cycle between sequencer and pin driver
    pnfs_cyc_if cyc ();

    pnfs_st_e                      st_q,    st_d;    // Sequencer state
    pnfs_pkg::pnfs_op_e            op_q,    op_d;    // Operation in hand
    logic [pnfs_pkg::ADDR_W-1:0]   addr_q,  addr_d;  // Target address
    logic [pnfs_pkg::DATA_W-1:0]   wdat_q,  wdat_d;  // Program word
    logic [2:0]                    idx_q,   idx_d;   // Command step index
    logic                          tog_q,   tog_d;   // Previous toggle bit
    logic [pnfs_pkg::TO_W-1:0]     to_q,    to_d;    // Busy-time counter
    logic                          req_q,   req_d;   // Cycle start pulse
    logic                          wr_q,    wr_d;    // Cycle kind
    pnfs_step_s                    cs_q,    cs_d;    // Cycle address/data
    logic                          rdy_q,   rdy_d;   // Command accepted
    logic                          rv_q,    rv_d;    // Response pulse
    logic [pnfs_pkg::DATA_W-1:0]   rdat_q,  rdat_d;  // Response data
    logic                          rto_q,   rto_d;   // Response timed out
    logic [pnfs_pkg::TO_W-1:0]     limit;            // Budget for this op

    // Command step table: unlock, setup (A0H for program), second unlock or program word, final erase code
    function automatic pnfs_step_s pnfs_step(input pnfs_pkg::pnfs_op_e op,
                                             input logic [2:0] idx,
                                             input logic [pnfs_pkg::ADDR_W-1:0] a,
                                             input logic [pnfs_pkg::DATA_W-1:0] d);
        pnfs_step_s s;
        s = '{addr: pnfs_pkg::UNLOCK_ADDR_A, data: pnfs_pkg::UNLOCK_DATA_A};
        case (idx)
            3'h0: s = '{addr: pnfs_pkg::UNLOCK_ADDR_A, data: pnfs_pkg::UNLOCK_DATA_A};
            3'h1: s = '{addr: pnfs_pkg::UNLOCK_ADDR_B, data: pnfs_pkg::UNLOCK_DATA_B};
            3'h2: s = '{addr: pnfs_pkg::UNLOCK_ADDR_A,
                        data: (op == pnfs_pkg::PNFS_OP_PGM) ? pnfs_pkg::PGM_CODE : pnfs_pkg::ERASE_SETUP};
            // caller pre-erases word; programming only clears bits
            // fourth program cycle carries word address and data
            3'h3: s = (op == pnfs_pkg::PNFS_OP_PGM) ? pnfs_step_s'{addr: a, data: d}
                      : pnfs_step_s'{addr: pnfs_pkg::UNLOCK_ADDR_A, data: pnfs_pkg::UNLOCK_DATA_A};
            3'h4: s = '{addr: pnfs_pkg::UNLOCK_ADDR_B, data: pnfs_pkg::UNLOCK_DATA_B};
            3'h5:
            begin
                case (op)
                    pnfs_pkg::PNFS_OP_SECT:
                        s = '{addr: {a[pnfs_pkg::ADDR_W-1:pnfs_pkg::SECT_LSB], 11'h000},
                              data: pnfs_pkg::SECT_CODE};
                    pnfs_pkg::PNFS_OP_BLOCK:
                        s = '{addr: {a[pnfs_pkg::ADDR_W-1:pnfs_pkg::BLOCK_LSB], 15'h0000},
                              data: pnfs_pkg::BLOCK_CODE};
                    // chip code at the fixed address
                    default:
                        s = '{addr: pnfs_pkg::CHIP_ADDR, data: pnfs_pkg::CHIP_CODE};
                endcase
            end
            default: s = '{addr: pnfs_pkg::UNLOCK_ADDR_A, data: pnfs_pkg::UNLOCK_DATA_A};
        endcase
        return s;
    endfunction : pnfs_step

    // Sequence length: program is short, every erase is six cycles
    function automatic logic [2:0] pnfs_len(input pnfs_pkg::pnfs_op_e op);
        return (op == pnfs_pkg::PNFS_OP_PGM) ? pnfs_pkg::PGM_STEPS : pnfs_pkg::ERASE_STEPS;
    endfunction : pnfs_len

    // program gets the 40 us budget, erase its own
    assign limit = (op_q == pnfs_pkg::PNFS_OP_PGM) ? pnfs_pkg::PGM_TIMEOUT_CYC
                 : pnfs_pkg::TO_W'(ERASE_TIMEOUT_CYC);

    // Sequencer next-state logic
    always_comb
    begin
        st_d   = st_q;
        op_d   = op_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        idx_d  = idx_q;
        tog_d  = tog_q;
        to_d   = to_q;
        req_d  = 1'b0;
        wr_d   = wr_q;
        cs_d   = cs_q;
        rv_d   = 1'b0;
        rdat_d = rdat_q;
        rto_d  = rto_q;
        // Busy time counts from the end of the last command cycle
        if (st_q == PNFS_ST_POLL1 || st_q == PNFS_ST_POLL2)
        begin
            to_d = to_q + 24'h000001;
        end
        case (st_q)
            PNFS_ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_d   = pnfs_pkg::pnfs_op_e'(cmd_op);
                    addr_d = cmd_addr;
                    wdat_d = cmd_wdata;
                    idx_d  = 3'h0;
                    rto_d  = 1'b0;
                    req_d  = 1'b1;
                    if (pnfs_pkg::pnfs_op_e'(cmd_op) == pnfs_pkg::PNFS_OP_READ)
                    begin
                        wr_d = 1'b0;
                        cs_d = '{addr: cmd_addr, data: 16'h0000};
                        st_d = PNFS_ST_READ;
                    end
                    else
                    begin
                        wr_d = 1'b1;
                        cs_d = pnfs_step(pnfs_pkg::pnfs_op_e'(cmd_op), 3'h0, cmd_addr, cmd_wdata);
                        st_d = PNFS_ST_CMD;
                    end
                end
            end
            PNFS_ST_CMD:
            begin
                if (cyc.done)
                begin
                    req_d = 1'b1;
                    if (idx_q == pnfs_len(op_q) - 3'h1)
                    begin
                        // last cycle done, erase/program now running
                        // watch completion by polling status reads
                        wr_d = 1'b0;
                        cs_d = '{addr: addr_q, data: 16'h0000};
                        to_d = 24'h000000;
                        st_d = PNFS_ST_POLL1;
                    end
                    else
                    begin
                        idx_d = idx_q + 3'h1;
                        cs_d  = pnfs_step(op_q, idx_q + 3'h1, addr_q, wdat_q);
                    end
                end
            end
            PNFS_ST_POLL1:
            begin
                if (cyc.done)
                begin
                    tog_d = cyc.rdata[pnfs_pkg::TOGGLE_BIT];
                    req_d = 1'b1;
                    st_d  = PNFS_ST_POLL2;
                end
            end
            PNFS_ST_POLL2:
            begin
                if (cyc.done)
                begin
                    req_d = 1'b1;
                    // a steady toggle bit marks the end
                    if (cyc.rdata[pnfs_pkg::TOGGLE_BIT] == tog_q)
                    begin
                        st_d = PNFS_ST_FINAL;
                    end
                    else if (to_q >= limit)
                    begin
                        // Stuck device: give up, report, stay usable
                        req_d = 1'b0;
                        rto_d = 1'b1;
                        rv_d  = 1'b1;
                        rdat_d = cyc.rdata;
                        st_d  = PNFS_ST_IDLE;
                    end
                    else
                    begin
                        tog_d = cyc.rdata[pnfs_pkg::TOGGLE_BIT];
                    end
                end
            end
            PNFS_ST_FINAL, PNFS_ST_READ:
            begin
                if (cyc.done)
                begin
                    // array data is read back with no further command
                    rv_d   = 1'b1;
                    rdat_d = cyc.rdata;
                    st_d   = PNFS_ST_IDLE;
                end
            end
            default:
            begin
                st_d = PNFS_ST_IDLE;
            end
        endcase
        // no new command is taken while an operation runs
        rdy_d = (st_d == PNFS_ST_IDLE) && !(st_q == PNFS_ST_IDLE && cmd_valid);
    end

    // Sequencer registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_q   <= PNFS_ST_IDLE;
            op_q   <= pnfs_pkg::PNFS_OP_READ;
            addr_q <= 18'h00000;
            wdat_q <= 16'h0000;
            idx_q  <= 3'h0;
            tog_q  <= 1'b0;
            to_q   <= 24'h000000;
            req_q  <= 1'b0;
            wr_q   <= 1'b0;
            cs_q   <= '{addr: 18'h00000, data: 16'h0000};
            rdy_q  <= 1'b0;
            rv_q   <= 1'b0;
            rdat_q <= 16'h0000;
            rto_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            op_q   <= op_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            idx_q  <= idx_d;
            tog_q  <= tog_d;
            to_q   <= to_d;
            req_q  <= req_d;
            wr_q   <= wr_d;
            cs_q   <= cs_d;
            rdy_q  <= rdy_d;
            rv_q   <= rv_d;
            rdat_q <= rdat_d;
            rto_q  <= rto_d;
        end
    end

    // Cycle request towards the pin driver
    assign cyc.req   = req_q;
    assign cyc.wr    = wr_q;
    assign cyc.addr  = cs_q.addr;
    assign cyc.wdata = cs_q.data;

    // User outputs from flops
    assign cmd_ready   = rdy_q;
    assign rsp_valid   = rv_q;
    assign rsp_rdata   = rdat_q;
    assign rsp_timeout = rto_q;

    // Pin driver; the data bus is driven only on write cycles
    pnfs_bus_cycle u_bus
    (
        .ref_clk          (ref_clk),
        .sys_rst          (sys_rst),
        .cyc              (cyc),
        .address_lines    (address_lines),
        .chip_sel_n       (chip_sel_n),
        .out_gate_n       (out_gate_n),
        .wr_strobe_n      (wr_strobe_n),
        .data_lines_wr    (data_lines_wr),
        .data_lines_wr_en (data_lines_wr_en),
        .data_lines_rd    (data_lines_rd)
    );

endmodule : pnfs_sequencer

// >>> pkg/pnfs_pkg.sv
package pnfs_pkg;

    // Bus widths of the flash array
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    // Operations the user may request
    typedef enum logic [2:0]
    {
        PNFS_OP_READ  = 3'h0,
        PNFS_OP_PGM   = 3'h1,
        PNFS_OP_SECT  = 3'h2,
        PNFS_OP_BLOCK = 3'h3,
        PNFS_OP_CHIP  = 3'h4
    } pnfs_op_e;

    // Unlock and command addresses
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 18'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 18'h02aaa;
    localparam logic [ADDR_W-1:0] CHIP_ADDR     = 18'h05555;

    // Unlock and command codes
    localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h0055;
    localparam logic [DATA_W-1:0] PGM_CODE      = 16'h00a0;
    localparam logic [DATA_W-1:0] ERASE_SETUP   = 16'h0080;
    localparam logic [DATA_W-1:0] SECT_CODE     = 16'h0030;
    localparam logic [DATA_W-1:0] BLOCK_CODE    = 16'h0050;
    localparam logic [DATA_W-1:0] CHIP_CODE     = 16'h0010;

    // Lowest address bit that selects a sector or a block
    localparam int SECT_LSB  = 11;
    localparam int BLOCK_LSB = 15;

    // Sequence lengths in bus cycles
    localparam logic [2:0] PGM_STEPS   = 3'h4;
    localparam logic [2:0] ERASE_STEPS = 3'h6;

    // Status bit positions
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;

    // Bus timing, in ns at the 100 MHz clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SETUP_NS    = 10;
    localparam int T_WP_NS       = 40;
    localparam int T_HOLD_NS     = 10;
    localparam int T_ACC_NS      = 70;
    localparam int CNT_W         = 4;
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WP_CYC    = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACC_CYC   = CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Longest program time and the matching cycle budget (rounded down)
    localparam int TO_W          = 24;
    localparam int PGM_MAX_US    = 40;
    localparam logic [TO_W-1:0] PGM_TIMEOUT_CYC = TO_W'(PGM_MAX_US * 1000 / CLK_PERIOD_NS);

    // Erase budget default: 100 ms expressed in cycles
    localparam int ERASE_MAX_MS  = 100;
    localparam int ERASE_TIMEOUT_DEF = ERASE_MAX_MS * 100000;

endpackage : pnfs_pkg

// >>> pkg/pnfs_cyc_if.sv
`timescale 1ns/1ps

// One flash bus cycle: request from the sequencer, completion from the pin driver
interface pnfs_cyc_if;
    logic                      req;    // One-cycle start pulse
    logic                      wr;     // High for a write cycle, low for a read
    logic [pnfs_pkg::ADDR_W-1:0] addr; // Address of the cycle
    logic [pnfs_pkg::DATA_W-1:0] wdata; // Data for a write cycle
    logic                      done;   // One-cycle end pulse
    logic [pnfs_pkg::DATA_W-1:0] rdata; // Data sampled by a read cycle

    modport seq (output req, wr, addr, wdata, input done, rdata);
    modport phy (input req, wr, addr, wdata, output done, rdata);
endinterface : pnfs_cyc_if

// >>> verilog/pnfs_bus_cycle.sv
`timescale 1ns/1ps

// Drives the flash pins through a single read or write bus cycle
module pnfs_bus_cycle
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // Cycle requests
    pnfs_cyc_if.phy                            cyc,
    // Flash pins
    output logic [pnfs_pkg::ADDR_W-1:0]        address_lines,
    output logic                               chip_sel_n,
    output logic                               out_gate_n,
    output logic                               wr_strobe_n,
    output logic [pnfs_pkg::DATA_W-1:0]        data_lines_wr,
    output logic                               data_lines_wr_en,
    input  wire logic [pnfs_pkg::DATA_W-1:0]   data_lines_rd
);

    // Cycle phases, Gray coded
    typedef enum logic [1:0]
    {
        PNFS_PH_IDLE   = 2'b00,
        PNFS_PH_SETUP  = 2'b01,
        PNFS_PH_STROBE = 2'b11,
        PNFS_PH_HOLD   = 2'b10
    } pnfs_ph_e;

    pnfs_ph_e                      ph_q,    ph_d;    // Current phase
    logic [pnfs_pkg::CNT_W-1:0]    cnt_q,   cnt_d;   // Cycles left in phase
    logic                          wr_q,    wr_d;    // Cycle kind
    logic [pnfs_pkg::ADDR_W-1:0]   addr_q,  addr_d;  // Address on the pins
    logic [pnfs_pkg::DATA_W-1:0]   dout_q,  dout_d;  // Data on the pins
    logic                          doe_q,   doe_d;   // Data drive enable
    logic                          ce_n_q,  ce_n_d;  // Chip select
    logic                          oe_n_q,  oe_n_d;  // Output gate
    logic                          we_n_q,  we_n_d;  // Write strobe
    logic                          done_q,  done_d;  // End pulse
    logic [pnfs_pkg::DATA_W-1:0]   rdat_q,  rdat_d;  // Sampled read data

    // Next-state logic for the pin sequence
    always_comb
    begin
        ph_d   = ph_q;
        cnt_d  = cnt_q;
        wr_d   = wr_q;
        addr_d = addr_q;
        dout_d = dout_q;
        doe_d  = doe_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        done_d = 1'b0;
        rdat_d = rdat_q;
        case (ph_q)
            PNFS_PH_IDLE:
            begin
                if (cyc.req)
                begin
                    // Address and data settle with chip select low, strobe still high
                    addr_d = cyc.addr;
                    dout_d = cyc.wdata;
                    wr_d   = cyc.wr;
                    doe_d  = cyc.wr;
                    ce_n_d = 1'b0;
                    cnt_d  = pnfs_pkg::SETUP_CYC - 4'h1;
                    ph_d   = PNFS_PH_SETUP;
                end
            end
            PNFS_PH_SETUP:
            begin
                if (cnt_q != 4'h0)
                begin
                    cnt_d = cnt_q - 4'h1;
                end
                else if (wr_q)
                begin
                    // strobe falls last, device takes address here
                    we_n_d = 1'b0;
                    cnt_d  = pnfs_pkg::WP_CYC - 4'h1;
                    ph_d   = PNFS_PH_STROBE;
                end
                else
                begin
                    // read with select and gate both low
                    oe_n_d = 1'b0;
                    cnt_d  = pnfs_pkg::ACC_CYC - 4'h1;
                    ph_d   = PNFS_PH_STROBE;
                end
            end
            PNFS_PH_STROBE:
            begin
                if (cnt_q != 4'h0)
                begin
                    cnt_d = cnt_q - 4'h1;
                end
                else
                begin
                    // strobe rises first, data still held
                    we_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    if (!wr_q)
                    begin
                        rdat_d = data_lines_rd;
                    end
                    cnt_d = pnfs_pkg::HOLD_CYC - 4'h1;
                    ph_d  = PNFS_PH_HOLD;
                end
            end
            PNFS_PH_HOLD:
            begin
                if (cnt_q != 4'h0)
                begin
                    cnt_d = cnt_q - 4'h1;
                end
                else
                begin
                    // Release the bus and report completion
                    ce_n_d = 1'b1;
                    doe_d  = 1'b0;
                    done_d = 1'b1;
                    ph_d   = PNFS_PH_IDLE;
                end
            end
            default:
            begin
                ph_d = PNFS_PH_IDLE;
            end
        endcase
    end

    // Registers; the pins idle deselected with the data bus released
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ph_q   <= PNFS_PH_IDLE;
            cnt_q  <= 4'h0;
            wr_q   <= 1'b0;
            addr_q <= 18'h00000;
            dout_q <= 16'h0000;
            doe_q  <= 1'b0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            done_q <= 1'b0;
            rdat_q <= 16'h0000;
        end
        else
        begin
            ph_q   <= ph_d;
            cnt_q  <= cnt_d;
            wr_q   <= wr_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            doe_q  <= doe_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            done_q <= done_d;
            rdat_q <= rdat_d;
        end
    end

    // Pin and handshake outputs straight from flops
    assign address_lines    = addr_q;
    assign chip_sel_n       = ce_n_q;
    assign out_gate_n       = oe_n_q;
    assign wr_strobe_n      = we_n_q;
    assign data_lines_wr    = dout_q;
    assign data_lines_wr_en = doe_q;
    assign cyc.done         = done_q;
    assign cyc.rdata        = rdat_q;

endmodule : pnfs_bus_cycle

// >>> testbench/pnfs_monitor.sv
`timescale 1ns/1ps
// Pin and handshake checks on the controller top ports
module pnfs_monitor
(
    input logic        ref_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid,
    input logic        chip_sel_n, out_gate_n, wr_strobe_n, data_lines_wr_en,
    input logic [2:0]  cmd_op,
    input logic [17:0] address_lines,
    input logic [15:0] data_lines_wr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Write strobe: four low cycles, then released
    sequence s_pulse;
        !wr_strobe_n [*4] ##1 wr_strobe_n;
    endsequence
    a_strobe_sel: assert property (!wr_strobe_n |-> !chip_sel_n) else $error("strobe without select");
    a_strobe_len: assert property ($fell(wr_strobe_n) |-> s_pulse) else $error("strobe width wrong");
    a_drive_gate: assert property (data_lines_wr_en |-> out_gate_n) else $error("drive during read");
    a_read_gate: assert property (!out_gate_n |-> wr_strobe_n && !chip_sel_n) else $error("bad read");
    a_addr_hold: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(address_lines))
        else $error("address moved");
    a_data_hold: assert property (!wr_strobe_n |=> $stable(data_lines_wr)) else $error("data moved");
    a_idle_desel: assert property (cmd_ready |-> chip_sel_n && wr_strobe_n) else $error("idle selected");
    a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready stuck");
    a_read_lat: assert property (cmd_valid && cmd_ready && cmd_op == 3'h0 |-> ##[11:13] rsp_valid)
        else $error("read late");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("response too long");
endmodule : pnfs_monitor
bind pnfs_sequencer pnfs_monitor u_pnfs_monitor (.*);

// >>> testbench/pnfs_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash device; busy times are short stand-ins
module pnfs_flash_model
#(
    parameter int PGM_NS = 10000,
    parameter int ERS_NS = 5000
)
(
    input  logic [17:0] address_lines,
    input  logic        chip_sel_n, out_gate_n, wr_strobe_n,
    input  logic [15:0] data_lines_wr,
    output logic [15:0] data_lines_rd
);
    logic [15:0] mem [int], keep [int]; // Absent words read as erased
    logic [17:0] a_q;                    // Latched address
    logic [15:0] last_q = 16'h0000;      // Last word driven
    logic [15:0] st_q   = 16'h0000;      // Word being programmed
    int step = 0;                        // Position in a sequence
    bit busy = 0, tog = 0, pgm = 0;
    function automatic logic [15:0] rd(int a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction : rd
    always @(negedge wr_strobe_n) if (!chip_sel_n) a_q = address_lines;
    always @(posedge busy) #(pgm ? PGM_NS : ERS_NS) busy = 0;
    // decode at strobe rise, only when idle
    always @(posedge wr_strobe_n) if (!chip_sel_n && !busy) case (step)
        0, 3: step = (a_q == 18'h05555 && data_lines_wr == 16'h00aa) ? step + 1 : 0;
        1, 4: step = (a_q == 18'h02aaa && data_lines_wr == 16'h0055) ? step + 1 : 0;
        2: step = a_q != 18'h05555 ? 0 : data_lines_wr == 16'h00a0 ? 9 : data_lines_wr == 16'h0080 ? 3 : 0;
        9: begin mem[a_q] = rd(a_q) & data_lines_wr; st_q = data_lines_wr; pgm = 1; busy = 1; step = 0; end
        5: begin
            keep.delete();
            foreach (mem[k]) if (!(data_lines_wr == 16'h0030 && k[17:11] == a_q[17:11] ||
                data_lines_wr == 16'h0050 && k[17:15] == a_q[17:15] ||
                data_lines_wr == 16'h0010 && a_q == 18'h05555)) keep[k] = mem[k];
            mem = keep;
            pgm = 0;
            busy = data_lines_wr == 16'h0030 || data_lines_wr == 16'h0050 ||
                (data_lines_wr == 16'h0010 && a_q == 18'h05555);
            step = 0;
        end
        default: step = 0;
    endcase
    // status only while busy, toggling per read
    always @(negedge out_gate_n) if (!chip_sel_n) begin
        tog = busy ? !tog : tog;
        last_q = busy ? {8'h00, pgm ? !st_q[7] : 1'b0, tog, 6'h00} : rd(address_lines);
    end
    // released lines show the inverse of the last word
    assign data_lines_rd = (!chip_sel_n && !out_gate_n) ? last_q : ~last_q;
endmodule : pnfs_flash_model

// >>> testbench/pnfs_sequencer_tb.sv
`timescale 1ns/1ps
// Command bench: driver notes expectations, checker pops them per response
module pnfs_sequencer_tb;
    `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
    logic        ref_clk = 0, sys_rst = 1, cmd_valid = 0;
    logic [2:0]  cmd_op = 0;
    logic [17:0] cmd_addr = 0, address_lines, a0, a1;
    logic [15:0] cmd_wdata = 0, rsp_rdata, data_lines_wr, data_lines_rd, d0, d1, e_rsp;
    logic        cmd_ready, rsp_valid, rsp_timeout, chip_sel_n, out_gate_n, wr_strobe_n, data_lines_wr_en;
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'h151e0035;
    int n_mismatch = 0, samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    pnfs_sequencer #(.ERASE_TIMEOUT_CYC(2000)) u_pnfs_sequencer (.*);
    pnfs_flash_model u_pnfs_flash_model (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Wait for ready, then hold the request over the taking edge
    task automatic do_cmd(input logic [2:0] op, input logic [17:0] a, input logic [15:0] d, input logic [15:0] e);
        exp_q.push_back(e);
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        cmd_valid <= 1; cmd_op <= op; cmd_addr <= a; cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 0;
    endtask : do_cmd
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // Response checker, sampled mid-cycle
    always @(negedge ref_clk) if (rsp_valid === 1'b1) begin
        e_rsp = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
        `CHK("rsp_rdata", e_rsp, rsp_rdata)
        `CHK("rsp_timeout", 1'b0, rsp_timeout)
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 0;
        a0 = 18'(rnd());
        d0 = 16'(rnd());
        d1 = 16'(rnd());
        a1 = a0 ^ 18'h00800;
        do_cmd(3'h0, a0, 16'h0000, 16'hffff);
        do_cmd(3'h1, a0, d0, d0);
        do_cmd(3'h1, a1, d1, d1);
        do_cmd(3'h0, a0, 16'h0000, d0);
        do_cmd(3'h2, a0, 16'h0000, 16'hffff);
        do_cmd(3'h0, a1, 16'h0000, d1);
        do_cmd(3'h3, a1, 16'h0000, 16'hffff);
        do_cmd(3'h1, a0, d0, d0);
        do_cmd(3'h4, a1, 16'h0000, 16'hffff);
        do_cmd(3'h0, a0, 16'h0000, 16'hffff);
        while (exp_q.size() != 0) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        summarize();
    end
    // Watchdog well beyond the expected run
    initial begin
        #500us;
        n_mismatch++;
        summarize();
    end
endmodule : pnfs_sequencer_tb
